//--- ecsp_top.sv
// encoder phase counting, channel 0/1 capture and three-phase pwm for channels 3 and 4
`timescale 1ns/100ps
module ecsp_top (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // register port
  input  wire logic [ecsp_pkg::ADDR_W-1:0] addr,
  input  wire logic [ecsp_pkg::DATA_W-1:0] wdata,
  input  wire logic                       wr_stb,
  input  wire logic                       rd_stb,
  output logic      [ecsp_pkg::DATA_W-1:0] rdata,
  // encoder phase pins
  input  wire logic                       phase_a_in_ch1,
  input  wire logic                       phase_b_in_ch1,
  input  wire logic                       phase_a_in_ch2,
  input  wire logic                       phase_b_in_ch2,
  // pwm pins
  output logic                            pwm1_pos_out,
  output logic                            pwm1_neg_out,
  output logic                            pwm2_pos_out,
  output logic                            pwm2_neg_out,
  output logic                            pwm3_pos_out,
  output logic                            pwm3_neg_out,
  output logic                            sync_toggle_out
);
  import ecsp_pkg::*;

  // quadrature decode: returns {count, up}
  function automatic logic [1:0] qdec(input logic [2:0] m, input logic a, input logic b,
                                      input logic a_p, input logic b_p);
    logic ar, af, br, bf, up, dn;
    ar = a & ~a_p;
    af = ~a & a_p;
    br = b & ~b_p;
    bf = ~b & b_p;
    up = 1'b0;
    dn = 1'b0;
    case (m)
      PH_MODE1: begin
        up = (br & a) | (bf & ~a) | (ar & ~b) | (af & b);
        dn = (bf & a) | (br & ~a) | (af & ~b) | (ar & b);
      end
      PH_MODE2: begin
        up = af & b;
        dn = af & ~b;
      end
      PH_MODE3: begin
        up = af & b & ~bf;
        dn = bf & a & ~af;
      end
      PH_MODE4: begin
        up = (br & a) | (bf & ~a);
        dn = (bf & a) | (br & ~a);
      end
      default: begin
        up = 1'b0;
        dn = 1'b0;
      end
    endcase
    qdec = {up | dn, up};
  endfunction

  // registers
  logic [15:0] ctrl_r, oc_r, status_r;
  logic [15:0] cnt0_r, spd_cmp_r, pos_cmp_r, pw_cap_r, pw_buf_r, pw_cnt_r;
  logic [15:0] cnt1_r, spd_cap_r, pos_cap_r, cnt2_r;
  logic [15:0] cnt3_r, cnt4_r, period3_r, turn1_r, turn2_r, turn3_r;
  logic        dir3_r;
  logic [3:0]  ph_s1_r, ph_s2_r, ph_p_r;
  logic [2:0]  pwm_lvl_r;
  ecsp_pwm_type pwm_st_r, pwm_st_nxt;

  // input synchronisers, then previous-sample stage for edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      ph_s1_r <= 4'h0;
      ph_s2_r <= 4'h0;
      ph_p_r  <= 4'h0;
    end else begin
      ph_s1_r <= {phase_b_in_ch2, phase_a_in_ch2, phase_b_in_ch1, phase_a_in_ch1};
      ph_s2_r <= ph_s1_r;
      ph_p_r  <= ph_s2_r;
    end
  end

  wire [2:0] mode1 = ctrl_r[CTL_CH1_MODE +: 3];
  wire [2:0] mode2 = ctrl_r[CTL_CH2_MODE +: 3];
  // prescaler and edge selections play no part here: phase pins alone clock it
  wire [1:0] q1 = qdec(mode1, ph_s2_r[0], ph_s2_r[1], ph_p_r[0], ph_p_r[1]);
  wire [1:0] q2 = qdec(mode2, ph_s2_r[2], ph_s2_r[3], ph_p_r[2], ph_p_r[3]);
  wire ovf1 = q1[1] & q1[0] & (cnt1_r == 16'hffff);
  wire unf1 = q1[1] & ~q1[0] & (cnt1_r == 16'h0000);
  wire ovf2 = q2[1] & q2[0] & (cnt2_r == 16'hffff);
  wire unf2 = q2[1] & ~q2[0] & (cnt2_r == 16'h0000);

  // channel 0 period timing
  wire ch0_run   = ctrl_r[CTL_CH0_RUN];
  wire spd_match = ch0_run & (cnt0_r == spd_cmp_r);
  wire pos_match = ch0_run & (cnt0_r == pos_cmp_r);
  wire pw_trig   = ctrl_r[CTL_PW_CAP] & q1[1];

  // bus decode
  wire wr_ctrl  = wr_stb & (addr == ADR_CTRL);
  wire wr_stat  = wr_stb & (addr == ADR_STATUS);
  wire wr_cnt0  = wr_stb & (addr == ADR_CNT0);
  wire wr_cnt1  = wr_stb & (addr == ADR_CNT1);
  wire wr_cnt2  = wr_stb & (addr == ADR_CNT2);
  wire wr_cnt3  = wr_stb & (addr == ADR_CNT3);
  wire wr_cnt4  = wr_stb & (addr == ADR_CNT4);
  wire wr_oc    = wr_stb & (addr == ADR_OUT_CTRL);

  // pwm controller state
  wire [1:0] pwm_sel = ctrl_r[CTL_PWM_MODE +: 2];
  wire       pwm_run = ctrl_r[CTL_PWM_RUN];
  always_comb begin
    pwm_st_nxt = pwm_st_r;
    case (pwm_st_r)
      PWM_IDLE:  if (pwm_run && pwm_sel == 2'h1) pwm_st_nxt = PWM_RSYNC;
                 else if (pwm_run && pwm_sel == 2'h2) pwm_st_nxt = PWM_COMPL;
      PWM_RSYNC: if (!pwm_run || pwm_sel != 2'h1) pwm_st_nxt = PWM_IDLE;
      PWM_COMPL: if (!pwm_run || pwm_sel != 2'h2) pwm_st_nxt = PWM_IDLE;
      default:   pwm_st_nxt = PWM_IDLE;
    endcase
  end
  wire rs_on   = (pwm_st_r == PWM_RSYNC);
  wire cp_on   = (pwm_st_r == PWM_COMPL);
  wire rs_clr  = rs_on & (cnt3_r == period3_r);
  wire cp_top  = cp_on & dir3_r & (cnt3_r == period3_r);
  wire cp_bot  = cp_on & ~dir3_r & (cnt3_r == 16'h0000);
  // turn round in the apex cycle itself so the triangle never overshoots its ends
  wire cp_up   = cp_top ? 1'b0 : (cp_bot ? 1'b1 : dir3_r);
  wire [2:0] turn_hit = {cnt4_r == turn3_r, cnt4_r == turn2_r, cnt3_r == turn1_r};
  wire [2:0] lvl_nxt  = rs_clr ? ~pwm_lvl_r : (pwm_lvl_r ^ turn_hit);
  wire       neg_lvl  = oc_r[OC_NEG_LVL];
  wire       pos_lvl  = oc_r[OC_POS_LVL];

  // control and compare registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r    <= CTRL_RST;
      oc_r      <= CTRL_RST;
      spd_cmp_r <= CMP_RST;
      pos_cmp_r <= CMP_RST;
      period3_r <= CMP_RST;
      turn1_r   <= CMP_RST;
      turn2_r   <= CMP_RST;
      turn3_r   <= CMP_RST;
      pwm_st_r  <= PWM_IDLE;
    end else begin
      pwm_st_r <= pwm_st_nxt;
      if (wr_ctrl) ctrl_r <= wdata;
      if (wr_oc) oc_r <= wdata;
      if (wr_stb && addr == ADR_SPD_CMP) spd_cmp_r <= wdata;
      if (wr_stb && addr == ADR_POS_CMP) pos_cmp_r <= wdata;
      if (wr_stb && addr == ADR_PERIOD3) period3_r <= wdata;
      if (wr_stb && addr == ADR_TURN1) turn1_r <= wdata;
      if (wr_stb && addr == ADR_TURN2) turn2_r <= wdata;
      if (wr_stb && addr == ADR_TURN3) turn3_r <= wdata;
    end
  end

  // channels 0, 1, 2 counting and capture
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt0_r    <= CNT_RST;
      cnt1_r    <= CNT_RST;
      cnt2_r    <= CNT_RST;
      spd_cap_r <= CNT_RST;
      pos_cap_r <= CNT_RST;
      pw_cap_r  <= CNT_RST;
      pw_buf_r  <= CNT_RST;
      pw_cnt_r  <= CNT_RST;
      status_r  <= CNT_RST;
    end else begin
      if (wr_cnt0) cnt0_r <= wdata;
      else if (pos_match) cnt0_r <= CNT_RST;
      else if (ch0_run) cnt0_r <= cnt0_r + 16'h0001;
      if (wr_cnt1) cnt1_r <= wdata;
      else if (q1[1]) cnt1_r <= q1[0] ? cnt1_r + 16'h0001 : cnt1_r - 16'h0001;
      if (wr_cnt2) cnt2_r <= wdata;
      else if (q2[1]) cnt2_r <= q2[0] ? cnt2_r + 16'h0001 : cnt2_r - 16'h0001;
      if (spd_match) spd_cap_r <= cnt1_r;
      if (pos_match) pos_cap_r <= cnt1_r;
      // width between successive multiplied encoder pulses, old capture to buffer
      if (pw_trig) begin
        pw_buf_r <= pw_cap_r;
        pw_cap_r <= pw_cnt_r;
        pw_cnt_r <= 16'h0001;
      end else if (pw_cnt_r != 16'hffff) begin
        pw_cnt_r <= pw_cnt_r + 16'h0001;
      end
      // writing a one clears an overflow or underflow flag; a new event in that cycle wins
      status_r[ST_OVF1] <= ovf1 | (status_r[ST_OVF1] & ~(wr_stat & wdata[ST_OVF1]));
      status_r[ST_UNF1] <= unf1 | (status_r[ST_UNF1] & ~(wr_stat & wdata[ST_UNF1]));
      status_r[ST_OVF2] <= ovf2 | (status_r[ST_OVF2] & ~(wr_stat & wdata[ST_OVF2]));
      status_r[ST_UNF2] <= unf2 | (status_r[ST_UNF2] & ~(wr_stat & wdata[ST_UNF2]));
      if (q1[1]) status_r[ST_DIR1] <= q1[0];
      if (q2[1]) status_r[ST_DIR2] <= q2[0];
    end
  end

  // channels 3 and 4 counters and pwm levels
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt3_r          <= CNT_RST;
      cnt4_r          <= CNT_RST;
      dir3_r          <= 1'b1;
      pwm_lvl_r       <= 3'h0;
      sync_toggle_out <= 1'b0;
    end else begin
      if (wr_cnt3) cnt3_r <= wdata;
      else if (rs_clr) cnt3_r <= CNT_RST;
      else if (rs_on) cnt3_r <= cnt3_r + 16'h0001;
      else if (cp_on) cnt3_r <= cp_up ? cnt3_r + 16'h0001 : cnt3_r - 16'h0001;
      if (wr_cnt4) cnt4_r <= wdata;
      else if (rs_clr) cnt4_r <= CNT_RST;
      else if (rs_on) cnt4_r <= cnt4_r + 16'h0001;
      else if (cp_on) cnt4_r <= cp_up ? cnt4_r + 16'h0001 : cnt4_r - 16'h0001;
      if (cp_top) dir3_r <= 1'b0;
      else if (cp_bot || !cp_on) dir3_r <= 1'b1;
      if (rs_on || cp_on) pwm_lvl_r <= lvl_nxt;
      else pwm_lvl_r <= 3'h0;
      if (cp_bot && oc_r[OC_TOGGLE]) sync_toggle_out <= ~sync_toggle_out;
    end
  end

  // pin drive: level 0 of a pair is the start-of-cycle state, active after a clear
  always_ff @(posedge clk) begin
    if (rst) begin
      pwm1_pos_out <= 1'b0;
      pwm1_neg_out <= 1'b0;
      pwm2_pos_out <= 1'b0;
      pwm2_neg_out <= 1'b0;
      pwm3_pos_out <= 1'b0;
      pwm3_neg_out <= 1'b0;
    end else begin
      pwm1_pos_out <= (rs_on | cp_on) & (lvl_nxt[0] ^ pos_lvl);
      pwm1_neg_out <= (rs_on | cp_on) & (~lvl_nxt[0] ^ neg_lvl);
      pwm2_pos_out <= (rs_on | cp_on) & (lvl_nxt[1] ^ pos_lvl);
      pwm2_neg_out <= (rs_on | cp_on) & (~lvl_nxt[1] ^ neg_lvl);
      pwm3_pos_out <= (rs_on | cp_on) & (lvl_nxt[2] ^ pos_lvl);
      pwm3_neg_out <= (rs_on | cp_on) & (~lvl_nxt[2] ^ neg_lvl);
    end
  end

  // read mux, data one cycle after the strobe; unmapped reads zero
  logic [15:0] rd_mux;
  always_comb begin
    case (addr)
      ADR_CTRL:     rd_mux = ctrl_r;
      ADR_STATUS:   rd_mux = status_r;
      ADR_CNT0:     rd_mux = cnt0_r;
      ADR_SPD_CMP:  rd_mux = spd_cmp_r;
      ADR_POS_CMP:  rd_mux = pos_cmp_r;
      ADR_PW_CAP:   rd_mux = pw_cap_r;
      ADR_PW_BUF:   rd_mux = pw_buf_r;
      ADR_CNT1:     rd_mux = cnt1_r;
      ADR_SPD_CAP:  rd_mux = spd_cap_r;
      ADR_POS_CAP:  rd_mux = pos_cap_r;
      ADR_CNT2:     rd_mux = cnt2_r;
      ADR_CNT3:     rd_mux = cnt3_r;
      ADR_CNT4:     rd_mux = cnt4_r;
      ADR_PERIOD3:  rd_mux = period3_r;
      ADR_TURN1:    rd_mux = turn1_r;
      ADR_TURN2:    rd_mux = turn2_r;
      ADR_TURN3:    rd_mux = turn3_r;
      ADR_OUT_CTRL: rd_mux = oc_r;
      default:      rd_mux = 16'h0000;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) rdata <= 16'h0000;
    else if (rd_stb) rdata <= rd_mux;
    else rdata <= 16'h0000;
  end
endmodule // ecsp_top

//--- ecsp_pkg.sv
// constants, register map and types for the encoder counter and synchronized pwm block
// Contract
// - phase counting on ch1/ch2 counts from phase pins, ignoring prescaler and edge select
// - overflow and underflow set flags; direction flag shows up or down
// - mode 1: full four-edge quadrature up/down decoding
// - ch1 uses phase_a/b_in_ch1, ch2 uses phase_a/b_in_ch2
// - mode 2: count only on falling A, up if B high, down if B low
// - mode 3: up on falling A with B high, down on falling B with A high
// - mode 4: count on B edges only, direction from A level
// - ch0 clears on position compare; speed and position compares time periods
// - ch1 count clock can trigger pulse width capture, buffered into its buffer
// - ch0 compare matches capture ch1 counter into speed and position captures
// - channels 3 and 4 make three pwm pairs sharing one transition point
// - six pwm pins active in reset-sync mode; ch3 counts up only
// - each negative pin is the inverse of its positive partner while OC_NEG_LVL equals OC_POS_LVL; both pins are held low while the pwm is stopped
// - ch3 and ch4 counters clear on period match then count up from zero
// - turn point registers set switching points of pairs 1, 2 and 3
// - each pair toggles on its turn point match and on counter clear
// - complementary mode uses same pins with up/down counting ch3 and ch4
// - sync_toggle_out toggles once per pwm period in complementary mode
package ecsp_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;
  // register word indices
  localparam logic [4:0] ADR_CTRL      = 5'h00;
  localparam logic [4:0] ADR_STATUS    = 5'h01;
  localparam logic [4:0] ADR_CNT0      = 5'h02;
  localparam logic [4:0] ADR_SPD_CMP   = 5'h03;
  localparam logic [4:0] ADR_POS_CMP   = 5'h04;
  localparam logic [4:0] ADR_PW_CAP    = 5'h05;
  localparam logic [4:0] ADR_PW_BUF    = 5'h06;
  localparam logic [4:0] ADR_CNT1      = 5'h07;
  localparam logic [4:0] ADR_SPD_CAP   = 5'h08;
  localparam logic [4:0] ADR_POS_CAP   = 5'h09;
  localparam logic [4:0] ADR_CNT2      = 5'h0a;
  localparam logic [4:0] ADR_CNT3      = 5'h0b;
  localparam logic [4:0] ADR_CNT4      = 5'h0c;
  localparam logic [4:0] ADR_PERIOD3   = 5'h0d;
  localparam logic [4:0] ADR_TURN1     = 5'h0e;
  localparam logic [4:0] ADR_TURN2     = 5'h0f;
  localparam logic [4:0] ADR_TURN3     = 5'h10;
  localparam logic [4:0] ADR_OUT_CTRL  = 5'h11;
  // control register fields
  localparam int unsigned CTL_CH1_MODE = 0;   // 3 bits: 0 off, 1..4 phase modes
  localparam int unsigned CTL_CH2_MODE = 3;   // 3 bits
  localparam int unsigned CTL_CH0_RUN  = 6;
  localparam int unsigned CTL_PW_CAP   = 7;
  localparam int unsigned CTL_PWM_MODE = 8;   // 2 bits
  localparam int unsigned CTL_PWM_RUN  = 10;
  // status fields: per channel overflow, underflow, direction
  localparam int unsigned ST_OVF1 = 0;
  localparam int unsigned ST_UNF1 = 1;
  localparam int unsigned ST_DIR1 = 2;
  localparam int unsigned ST_OVF2 = 3;
  localparam int unsigned ST_UNF2 = 4;
  localparam int unsigned ST_DIR2 = 5;
  // output control fields
  localparam int unsigned OC_NEG_LVL = 0;
  localparam int unsigned OC_POS_LVL = 1;
  localparam int unsigned OC_TOGGLE  = 2;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] CMP_RST  = 16'hffff;
  typedef enum logic [2:0] {
    PH_MODE1 = 3'h1,
    PH_MODE2 = 3'h2,
    PH_MODE3 = 3'h3,
    PH_MODE4 = 3'h4
  } ecsp_phase_type;
  typedef enum logic [2:0] {
    PWM_IDLE  = 3'b001,
    PWM_RSYNC = 3'b010,
    PWM_COMPL = 3'b100
  } ecsp_pwm_type;
endpackage

//--- ecsp_properties.sv
// concurrent checks on the pins of the encoder counter and pwm block
`timescale 1ns/100ps
module ecsp_properties (
  // clock and reset
  input wire logic                        clk,
  input wire logic                        rst,
  // register port
  input wire logic [ecsp_pkg::ADDR_W-1:0] addr,
  input wire logic [ecsp_pkg::DATA_W-1:0] wdata,
  input wire logic                        wr_stb,
  input wire logic                        rd_stb,
  input wire logic [ecsp_pkg::DATA_W-1:0] rdata,
  // phase pins
  input wire logic                        phase_a_in_ch1,
  input wire logic                        phase_b_in_ch1,
  input wire logic                        phase_a_in_ch2,
  input wire logic                        phase_b_in_ch2,
  // pwm pins
  input wire logic                        pwm1_pos_out,
  input wire logic                        pwm1_neg_out,
  input wire logic                        pwm2_pos_out,
  input wire logic                        pwm2_neg_out,
  input wire logic                        pwm3_pos_out,
  input wire logic                        pwm3_neg_out,
  input wire logic                        sync_toggle_out
);
  import ecsp_pkg::*;
  logic [15:0] ctl_r;
  logic [15:0] oc_r;
  logic [1:0]  stl_r;
  // shadow of the mode registers; checks wait until a write has reached the pins
  wire logic   cfg_wr = wr_stb && (addr == ADR_CTRL || addr == ADR_OUT_CTRL);
  wire logic   run    = stl_r == 2'h3 && ctl_r[CTL_PWM_RUN];
  wire logic   rsync  = run && ctl_r[9:8] == 2'h1;
  wire logic   compl  = run && ctl_r[9:8] == 2'h2 && oc_r[OC_TOGGLE];
  wire logic   lvl_eq = oc_r[OC_NEG_LVL] == oc_r[OC_POS_LVL];
  wire logic   quiet  = stl_r == 2'h3 && !compl;
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_r <= CTRL_RST;
      oc_r  <= 16'h0000;
      stl_r <= 2'h0;
    end else begin
      if (wr_stb && addr == ADR_CTRL) ctl_r <= wdata;
      if (wr_stb && addr == ADR_OUT_CTRL) oc_r <= wdata;
      if (cfg_wr) stl_r <= 2'h0;
      else if (stl_r != 2'h3) stl_r <= stl_r + 2'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_inv1;
    rsync |-> (pwm1_pos_out ^ pwm1_neg_out) == lvl_eq;
  endproperty
  property p_inv2;
    rsync |-> (pwm2_pos_out ^ pwm2_neg_out) == lvl_eq;
  endproperty
  property p_inv3;
    rsync |-> (pwm3_pos_out ^ pwm3_neg_out) == lvl_eq;
  endproperty
  property p_idle;
    stl_r == 2'h3 && !ctl_r[CTL_PWM_RUN] |-> {pwm1_pos_out, pwm1_neg_out, pwm2_pos_out,
      pwm2_neg_out, pwm3_pos_out, pwm3_neg_out} == 6'h00;
  endproperty
  property p_sync_still;
    quiet |=> $stable(sync_toggle_out);
  endproperty
  property p_sync_pace;
    compl && $changed(sync_toggle_out) |=> $stable(sync_toggle_out) [*2];
  endproperty
  property p_rd_idle;
    !rd_stb |=> rdata == 16'h0000;
  endproperty
  property p_rd_unmapped;
    rd_stb && addr > ADR_OUT_CTRL |=> rdata == 16'h0000;
  endproperty
  a_inv1: assert property (p_inv1) else $error("pair 1 negative pin wrong");
  a_inv2: assert property (p_inv2) else $error("pair 2 negative pin wrong");
  a_inv3: assert property (p_inv3) else $error("pair 3 negative pin wrong");
  a_idle: assert property (p_idle) else $error("pwm pin active while stopped");
  a_sync_still: assert property (p_sync_still) else $error("sync pin moved");
  a_sync_pace: assert property (p_sync_pace) else $error("sync pin too fast");
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read nonzero");
  c_rsync: cover property (rsync && $rose(pwm1_pos_out));
  c_compl: cover property (compl && $changed(sync_toggle_out));
  c_read: cover property (rd_stb && addr == ADR_STATUS);
endmodule // ecsp_properties
bind ecsp_top ecsp_properties u_ecsp_properties (.clk(clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .phase_a_in_ch1(phase_a_in_ch1), .phase_b_in_ch1(phase_b_in_ch1),
  .phase_a_in_ch2(phase_a_in_ch2), .phase_b_in_ch2(phase_b_in_ch2),
  .pwm1_pos_out(pwm1_pos_out), .pwm1_neg_out(pwm1_neg_out), .pwm2_pos_out(pwm2_pos_out),
  .pwm2_neg_out(pwm2_neg_out), .pwm3_pos_out(pwm3_pos_out), .pwm3_neg_out(pwm3_neg_out),
  .sync_toggle_out(sync_toggle_out));

//--- ecsp_enc_model.sv
// two-phase encoder driving one channel's phase pins
`timescale 1ns/100ps
module ecsp_enc_model (
  // clock
  input  wire logic clk,
  // motion request, one quarter cycle per pulse
  input  wire logic step,
  input  wire logic rev,
  // phase pins
  output logic      pa,
  output logic      pb
);
  logic [1:0] pos_r;
  // gray order: only one phase moves per step, a leads b going forward
  assign pa = pos_r == 2'h1 || pos_r == 2'h2;
  assign pb = pos_r[1];
  initial pos_r = 2'h0;
  always_ff @(posedge clk) begin
    if (step) pos_r <= rev ? pos_r - 2'h1 : pos_r + 2'h1;
  end
endmodule // ecsp_enc_model

//--- ecsp_top_tb_top.sv
// self-checking bench for the encoder counter and pwm block
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ecsp_top_tb_top;
  import ecsp_pkg::*;
  logic        clk, rst, wr_stb, rd_stb;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, d;
  logic        pa1, pb1, pa2, pb2, st1, rv1, st2, rv2;
  logic        p1p, p1n, p2p, p2n, p3p, p3n, tog;
  int          n_fail, tests_run, c;
  ecsp_top u_ecsp_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .phase_a_in_ch1(pa1), .phase_b_in_ch1(pb1),
    .phase_a_in_ch2(pa2), .phase_b_in_ch2(pb2), .pwm1_pos_out(p1p), .pwm1_neg_out(p1n),
    .pwm2_pos_out(p2p), .pwm2_neg_out(p2n), .pwm3_pos_out(p3p), .pwm3_neg_out(p3n),
    .sync_toggle_out(tog));
  ecsp_enc_model u_ecsp_enc_model_1 (.clk(clk), .step(st1), .rev(rv1), .pa(pa1), .pb(pb1));
  ecsp_enc_model u_ecsp_enc_model_2 (.clk(clk), .step(st2), .rev(rv2), .pa(pa2), .pb(pb2));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk);
    addr   <= a;
    wdata  <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    v = rdata;
  endtask
  // steps spaced wider than the input synchronizer so no edge is merged
  task automatic move(input logic e1, r1, e2, r2, input int n);
    repeat (n) begin
      @(posedge clk);
      {st1, rv1, st2, rv2} <= {e1, r1, e2, r2};
      @(posedge clk);
      {st1, st2} <= 2'b00;
      repeat (5) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask
  // cycles until the watched pin changes, given up after 100
  task automatic wait_chg(input int sel, output int cyc);
    logic v;
    v = sel ? tog : p1p;
    cyc = 0;
    while ((sel ? tog : p1p) === v && cyc < 100) begin
      @(posedge clk);
      #1;
      cyc++;
    end
  endtask
  task automatic t_modes;
    logic [15:0] c1, c2;
    int          per [4] = '{4, 1, 1, 2};
    for (int m = 1; m <= 4; m++) begin
      wr(ADR_CTRL, 16'(m) | (16'(m) << 3));
      rd(ADR_CNT1, c1);
      rd(ADR_CNT2, c2);
      move(1'b1, 1'b0, 1'b1, 1'b1, 4);
      move(1'b1, 1'b0, 1'b0, 1'b0, 4);
      rd(ADR_CNT1, d);
      `CHK(d, c1 + 16'(2 * per[m - 1]))
      rd(ADR_CNT2, d);
      `CHK(d, c2 - 16'(per[m - 1]))
    end
    $display("phase modes done");
  endtask
  task automatic t_flags;
    wr(ADR_CTRL, 16'h0001);
    wr(ADR_CNT1, 16'h0000);
    wr(ADR_STATUS, 16'h003f);
    move(1'b1, 1'b1, 1'b0, 1'b0, 1);
    rd(ADR_CNT1, d);
    `CHK(d, 16'hffff)
    rd(ADR_STATUS, d);
    `CHK(d[2:0], 3'b010)
    move(1'b1, 1'b0, 1'b0, 1'b0, 1);
    rd(ADR_STATUS, d);
    `CHK(d[2:0], 3'b111)
    rd(5'h1f, d);
    `CHK(d, 16'h0000)
    $display("flags done");
  endtask
  task automatic t_capture;
    wr(ADR_CNT1, 16'h1234);
    wr(ADR_SPD_CMP, 16'h0003);
    wr(ADR_POS_CMP, 16'h0009);
    wr(ADR_CNT0, 16'h0000);
    wr(ADR_CTRL, 16'h00c1);
    repeat (24) @(posedge clk);
    rd(ADR_SPD_CAP, d);
    `CHK(d, 16'h1234)
    rd(ADR_POS_CAP, d);
    `CHK(d, 16'h1234)
    rd(ADR_CNT0, d);
    `CHK(d < 16'h000a, 1'b1)
    move(1'b1, 1'b0, 1'b0, 1'b0, 2);
    rd(ADR_PW_CAP, d);
    `CHK(d, 16'h0007)
    $display("capture done");
  endtask
  task automatic t_rsync;
    int f [3] = '{0, 0, 0};
    logic [2:0] lo;
    wr(ADR_CNT3, 16'h0000);
    wr(ADR_CNT4, 16'h0000);
    wr(ADR_PERIOD3, 16'h0007);
    wr(ADR_TURN1, 16'h0002);
    wr(ADR_TURN2, 16'h0003);
    wr(ADR_TURN3, 16'h0005);
    wr(ADR_OUT_CTRL, 16'h0003);
    wr(ADR_CTRL, 16'h0500);
    if (p1p !== 1'b1) wait_chg(0, c);
    wait_chg(0, c);
    wait_chg(0, c);
    for (int i = 1; i <= 8; i++) begin
      @(posedge clk);
      #1;
      if (p1p !== 1'b1 && f[0] == 0) f[0] = i;
      if (p2p !== 1'b1 && f[1] == 0) f[1] = i;
      if (p3p !== 1'b1 && f[2] == 0) f[2] = i;
      if (i == 7) lo = {p1p, p2p, p3p};
    end
    `CHK(f[1] - f[0], 1)
    `CHK(f[2] - f[0], 3)
    `CHK(lo, 3'b000)
    `CHK({p1p, p2p, p3p}, 3'b111)
    wr(ADR_OUT_CTRL, 16'h0002);
    repeat (6) @(posedge clk);
    `CHK(p1p ^ p1n, 1'b0)
    $display("reset sync pwm done");
  endtask
  task automatic t_compl;
    wr(ADR_OUT_CTRL, 16'h0007);
    wr(ADR_CTRL, 16'h0600);
    wait_chg(1, c);
    wait_chg(1, c);
    `CHK(c, 14)
    wr(ADR_CTRL, 16'h0000);
    repeat (4) @(posedge clk);
    `CHK({p1p, p1n, p2p, p2n, p3p, p3n}, 6'h00)
    $display("complementary pwm done");
  endtask
  task automatic results;
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    {rst, wr_stb, rd_stb, addr, wdata} = {1'b1, 2'b00, 5'h00, 16'h0000};
    {st1, rv1, st2, rv2} = 4'h0;
    n_fail = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_modes;
    t_flags;
    t_capture;
    t_rsync;
    t_compl;
    results;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    results;
  end
endmodule // ecsp_top_tb_top
